// ==== common/sxr_pkg.sv ====
// constants shared by the synchronous slave receiver and its link master
package sxr_pkg;
	// ========================================================
	// register byte offsets, one aligned 32-bit word each
	localparam logic [7:0] OFS_RX_DATA   = 8'h00;
	localparam logic [7:0] OFS_RX_STAT   = 8'h04;
	localparam logic [7:0] OFS_TX_STAT   = 8'h08;
	localparam logic [7:0] OFS_BAUD_CTL  = 8'h0c;
	localparam logic [7:0] OFS_INT_STAT  = 8'h10;
	localparam logic [7:0] OFS_INT_EN    = 8'h14;
	localparam logic [7:0] OFS_INT_CLR   = 8'h18;
	// ========================================================
	// receive status/control field positions
	localparam int BIT_PORT_EN   = 7;
	localparam int BIT_NINE_SEL  = 6;
	localparam int BIT_SINGLE_EN = 5;
	localparam int BIT_CONT_EN   = 4;
	localparam int BIT_OVERRUN   = 1;
	localparam int BIT_NINTH     = 0;
	// transmit status/control and baud control fields
	localparam int BIT_CLK_SRC = 7;
	localparam int BIT_SYNC  = 4;
	localparam int BIT_RCIDL = 6;
	// interrupt status/enable/clear layout
	localparam int INT_RXDONE = 0;
	localparam int INT_OVERRUN = 1;
	localparam int INT_W      = 2;
	// ========================================================
	// sizes and reset values
	localparam int CHAR_W     = 9;
	localparam int FIFO_DEPTH = 2;
	localparam int CNT_W      = 4;
	localparam logic [CNT_W-1:0] BITS_8 = 4'h8;
	localparam logic [CNT_W-1:0] BITS_9 = 4'h9;
	localparam logic [31:0] REG_ZERO  = 32'h0000_0000;
	// ========================================================
	// timing: link clock half period driven by the master end
	localparam int PCLK_NS       = 10;
	localparam int LINK_HALF_NS  = 80;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
endpackage

// ==== common/sxr_link_if.sv ====
// two-wire synchronous link between the master end and the slave receiver
`timescale 1ns/100ps
interface sxr_link_if;
	logic sclk_out;
	logic sclk_oe;
	logic sdat_out;
	logic sdat_oe;
	logic serial_clock_pin;
	logic serial_data_pin;
	// undriven lines float high through a pull-up
	assign serial_clock_pin = sclk_oe ? sclk_out : 1'b1;
	assign serial_data_pin  = sdat_oe ? sdat_out : 1'b1;
	modport master (
		output sclk_out,
		output sclk_oe,
		output sdat_out,
		output sdat_oe
	);
	modport slave (
		input serial_clock_pin,
		input serial_data_pin
	);
endinterface

// ==== rtl/sxr_sync_master.sv ====
// external master end: drives the link clock and data, lsb first
`timescale 1ns/100ps
module sxr_sync_master
	import sxr_pkg::*;
#(
	parameter int HALF_CYC = LINK_HALF_CYC
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// user side
	input  wire logic              send,
	input  wire logic              nine_bit,
	input  wire logic [CHAR_W-1:0] char_in,
	output logic                   busy,
	output logic                   done,
	// link
	sxr_link_if.master             link
);
	// ========================================================
	// state
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOW  = 3'b010,
		ST_HIGH = 3'b100
	} sxr_mst_state_type;

	sxr_mst_state_type       state_reg, state_next;
	logic [CHAR_W-1:0]       shift_reg, shift_next;
	logic [CNT_W-1:0]        bits_reg, bits_next;
	logic [CNT_W-1:0]        nbits_reg, nbits_next;
	logic [15:0]             tmr_reg, tmr_next;
	logic                    sclk_reg, sclk_next;
	logic                    sdat_reg, sdat_next;
	logic                    oe_reg;
	logic                    done_reg, done_next;

	localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bits_next  = bits_reg;
		nbits_next = nbits_reg;
		tmr_next   = tmr_reg;
		sclk_next  = sclk_reg;
		sdat_next  = sdat_reg;
		done_next  = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (send) begin
					shift_next = char_in;
					nbits_next = nine_bit ? BITS_9 : BITS_8;
					bits_next  = '0;
					tmr_next   = '0;
					sdat_next  = char_in[0];
					state_next = ST_LOW;
				end
			end
			ST_LOW: begin
				tmr_next = tmr_reg + 16'h0001;
				if (tmr_reg == HALF_LAST) begin
					// rising edge: the slave samples here
					tmr_next   = '0;
					sclk_next  = 1'b1;
					state_next = ST_HIGH;
				end
			end
			ST_HIGH: begin
				tmr_next = tmr_reg + 16'h0001;
				if (tmr_reg == HALF_LAST) begin
					tmr_next   = '0;
					sclk_next  = 1'b0;
					shift_next = {1'b0, shift_reg[CHAR_W-1:1]};
					sdat_next  = shift_reg[1];
					bits_next  = bits_reg + 4'h1;
					if (bits_reg + 4'h1 == nbits_reg) begin
						done_next  = 1'b1;
						state_next = ST_IDLE;
					end else begin
						state_next = ST_LOW;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			shift_reg <= '0;
			bits_reg  <= '0;
			nbits_reg <= BITS_8;
			tmr_reg   <= '0;
			sclk_reg  <= 1'b0;
			sdat_reg  <= 1'b0;
			oe_reg    <= 1'b0;
			done_reg  <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bits_reg  <= bits_next;
			nbits_reg <= nbits_next;
			tmr_reg   <= tmr_next;
			sclk_reg  <= sclk_next;
			sdat_reg  <= sdat_next;
			// the master alone drives both lines once out of reset
			oe_reg    <= 1'b1;
			done_reg  <= done_next;
		end
	end

	assign link.sclk_out = sclk_reg;
	assign link.sclk_oe  = oe_reg;
	assign link.sdat_out = sdat_reg;
	assign link.sdat_oe  = oe_reg;
	assign busy          = (state_reg != ST_IDLE);
	assign done          = done_reg;
endmodule // sxr_sync_master

// ==== rtl/sxr_slave_rx.sv ====
// synchronous slave receiver with apb registers and receive fifo
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - software picks sync, port enable, external clock
// - software makes both pins inputs only
// - software sets interrupt enables for delivery
// - nine-bit option receives nine data bits
// - reception only while continuous-receive enable set
// - completion sets flag; irq only if enabled
// - ninth bit shown in receive status
// - low eight bits read through fifo
// - overrun held until receive or port enable cleared
// - unimplemented bits read zero, ignore writes
// - single-receive enable ignored in slave mode
// - characters still land and interrupt during sleep
module sxr_slave_rx
	import sxr_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq,
	// link
	sxr_link_if.slave        link
);
	localparam int PW = $clog2(DEPTH);

	// ========================================================
	// pin synchronisers
	logic sck_s1, sck_s2, sck_s3;
	logic dat_s1, dat_s2;
	logic sck_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// start at the pulled-up idle level: no false edge after reset
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
			dat_s1 <= 1'b1;
			dat_s2 <= 1'b1;
		end else if (ce) begin
			sck_s1 <= link.serial_clock_pin;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			dat_s1 <= link.serial_data_pin;
			dat_s2 <= dat_s1;
		end
	end
	assign sck_rise = sck_s2 & ~sck_s3;

	// ========================================================
	// state
	logic                  serial_port_enable_reg;
	logic                  serial_port_enable_next;
	logic                  nine_bit_receive_select_reg;
	logic                  nine_bit_receive_select_next;
	logic                  single_receive_enable_reg;
	logic                  single_receive_enable_next;
	logic                  continuous_receive_enable_reg;
	logic                  continuous_receive_enable_next;
	logic                  clock_source_select_reg;
	logic                  clock_source_select_next;
	logic                  sync_reg, sync_next;
	logic                  overrun_error_flag_reg;
	logic                  overrun_error_flag_next;
	logic [CHAR_W-1:0]     shift_reg, shift_next;
	logic [CNT_W-1:0]      cnt_reg, cnt_next;
	logic [CHAR_W-1:0]     mem_reg [DEPTH];
	logic [CHAR_W-1:0]     mem_next [DEPTH];
	logic [PW-1:0]         wp_reg, wp_next;
	logic [PW-1:0]         rp_reg, rp_next;
	logic [PW:0]           fill_reg, fill_next;
	logic [INT_W-1:0]      ist_reg, ist_next;
	logic [INT_W-1:0]      ien_reg, ien_next;
	logic [31:0]           prdata_next;
	logic                  pready_next, pslverr_next, irq_next;

	logic                  active, setup, wr_acc, rd_acc, pop, push;
	logic [CNT_W-1:0]      nbits;
	logic [CHAR_W-1:0]     head;
	logic [INT_W-1:0]      ev;

	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;
	assign rd_acc = psel & penable & pready & ~pwrite;
	assign head   = mem_reg[rp_reg];
	// slave mode with external clock; single-receive is ignored
	assign active = serial_port_enable_reg & sync_reg
		& ~clock_source_select_reg & continuous_receive_enable_reg;
	assign nbits  = nine_bit_receive_select_reg ? BITS_9 : BITS_8;
	assign pop    = rd_acc & (paddr == OFS_RX_DATA) & (fill_reg != '0);

	always_comb begin
		serial_port_enable_next        = serial_port_enable_reg;
		nine_bit_receive_select_next   = nine_bit_receive_select_reg;
		single_receive_enable_next     = single_receive_enable_reg;
		continuous_receive_enable_next = continuous_receive_enable_reg;
		clock_source_select_next       = clock_source_select_reg;
		sync_next = sync_reg;
		overrun_error_flag_next        = overrun_error_flag_reg;
		shift_next = shift_reg;
		cnt_next  = cnt_reg;
		mem_next  = mem_reg;
		wp_next   = wp_reg;
		rp_next   = rp_reg;
		ien_next  = ien_reg;
		ev        = '0;
		push      = 1'b0;
		// ----- receive shifter; runs regardless of sleep
		if (active && !overrun_error_flag_reg && sck_rise) begin
			shift_next[cnt_reg] = dat_s2;
			cnt_next = cnt_reg + 4'h1;
			if (cnt_reg + 4'h1 == nbits) begin
				cnt_next = '0;
				if (fill_reg == (PW+1)'(DEPTH) && !pop) begin
					// fifo full: character dropped, shifter blocked
					overrun_error_flag_next = 1'b1;
					ev[INT_OVERRUN] = 1'b1;
				end else begin
					push = 1'b1;
					mem_next[wp_reg] = nine_bit_receive_select_reg ? shift_next
						: {1'b0, shift_next[7:0]};
					wp_next = (wp_reg == PW'(DEPTH - 1)) ? '0
						: wp_reg + PW'(1);
					ev[INT_RXDONE] = 1'b1;
				end
			end
		end
		if (pop) begin
			rp_next = (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + PW'(1);
		end
		fill_next = fill_reg + (PW+1)'(push) - (PW+1)'(pop);
		// ----- register writes; only implemented bits stored
		if (wr_acc) begin
			case (paddr)
				OFS_RX_STAT: begin
					serial_port_enable_next = pwdata[BIT_PORT_EN];
					nine_bit_receive_select_next = pwdata[BIT_NINE_SEL];
					single_receive_enable_next = pwdata[BIT_SINGLE_EN];
					continuous_receive_enable_next = pwdata[BIT_CONT_EN];
				end
				OFS_TX_STAT: begin
					clock_source_select_next = pwdata[BIT_CLK_SRC];
					sync_next = pwdata[BIT_SYNC];
				end
				OFS_INT_EN: ien_next = pwdata[INT_W-1:0];
				default: ;
			endcase
		end
		// ----- dropping receive enable clears overrun and partial char;
		// an overrun landing in that same cycle holds the flag for one cycle only; it still sets its status bit while port enable stays set
		if (!continuous_receive_enable_next
			|| !serial_port_enable_next) begin
			overrun_error_flag_next = ev[INT_OVERRUN];
			cnt_next  = '0;
		end
		// dropping port enable resets the whole receive path
		if (!serial_port_enable_next) begin
			overrun_error_flag_next = 1'b0;
			wp_next   = '0;
			rp_next   = '0;
			fill_next = '0;
			ev        = '0;
		end
		// set wins over a same-cycle clear
		ist_next = ist_reg;
		if (wr_acc && paddr == OFS_INT_CLR) begin
			ist_next = ist_reg & ~pwdata[INT_W-1:0];
		end
		ist_next = ist_next | ev;
		irq_next = |(ist_next & ien_next);
		// ----- apb answer prepared in setup, given in access
		pready_next  = setup;
		pslverr_next = 1'b0;
		prdata_next  = REG_ZERO;
		if (setup) begin
			case (paddr)
				OFS_RX_DATA: prdata_next[7:0] = head[7:0];
				OFS_RX_STAT: begin
					prdata_next[BIT_PORT_EN]   = serial_port_enable_reg;
					prdata_next[BIT_NINE_SEL]  = nine_bit_receive_select_reg;
					prdata_next[BIT_SINGLE_EN] = single_receive_enable_reg;
					prdata_next[BIT_CONT_EN]   = continuous_receive_enable_reg;
					prdata_next[BIT_OVERRUN]   = overrun_error_flag_reg;
					prdata_next[BIT_NINTH]     = head[CHAR_W-1];
				end
				OFS_TX_STAT: begin
					prdata_next[BIT_CLK_SRC] = clock_source_select_reg;
					prdata_next[BIT_SYNC] = sync_reg;
				end
				OFS_BAUD_CTL: prdata_next[BIT_RCIDL] = (cnt_reg == '0);
				OFS_INT_STAT: prdata_next[INT_W-1:0] = ist_reg;
				OFS_INT_EN:   prdata_next[INT_W-1:0] = ien_reg;
				OFS_INT_CLR: ;
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_port_enable_reg        <= 1'b0;
			nine_bit_receive_select_reg   <= 1'b0;
			single_receive_enable_reg     <= 1'b0;
			continuous_receive_enable_reg <= 1'b0;
			clock_source_select_reg       <= 1'b0;
			sync_reg  <= 1'b0;
			overrun_error_flag_reg        <= 1'b0;
			shift_reg <= '0;
			cnt_reg   <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wp_reg    <= '0;
			rp_reg    <= '0;
			fill_reg  <= '0;
			ist_reg   <= '0;
			ien_reg   <= '0;
			prdata    <= REG_ZERO;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			irq       <= 1'b0;
		end else if (ce) begin
			serial_port_enable_reg        <= serial_port_enable_next;
			nine_bit_receive_select_reg   <= nine_bit_receive_select_next;
			single_receive_enable_reg     <= single_receive_enable_next;
			continuous_receive_enable_reg <= continuous_receive_enable_next;
			clock_source_select_reg       <= clock_source_select_next;
			sync_reg  <= sync_next;
			overrun_error_flag_reg        <= overrun_error_flag_next;
			shift_reg <= shift_next;
			cnt_reg   <= cnt_next;
			mem_reg   <= mem_next;
			wp_reg    <= wp_next;
			rp_reg    <= rp_next;
			fill_reg  <= fill_next;
			ist_reg   <= ist_next;
			ien_reg   <= ien_next;
			prdata    <= prdata_next;
			pready    <= pready_next;
			pslverr   <= pslverr_next;
			irq       <= irq_next;
		end
	end
endmodule // sxr_slave_rx

// ==== dv/sxr_link_checker.sv ====
// link wire checker between master end and slave receiver
`timescale 1ns/100ps
module sxr_link_checker #(
	parameter int HALF = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// master drive
	input wire logic sclk_out,
	input wire logic sclk_oe,
	input wire logic sdat_out,
	input wire logic sdat_oe,
	// resolved pins
	input wire logic serial_clock_pin,
	input wire logic serial_data_pin
);
	logic [7:0] hi_reg;
	logic [7:0] hi_next;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// length of the current high half of the link clock
	always_comb begin
		hi_next = sclk_out ? hi_reg + 8'h01 : 8'h00;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_reg <= 8'h00;
		else
			hi_reg <= hi_next;
	end
	// ==========================================================
	sequence s_rise;
		$rose(sclk_out);
	endsequence
	sequence s_hold;
		(sclk_out && $stable(sdat_out)) [*4];
	endsequence
	property p_hold_high;
		s_rise |-> s_hold;
	endproperty
	property p_change_low;
		$changed(sdat_out) |-> !sclk_out;
	endproperty
	property p_high_len;
		$fell(sclk_out) |-> hi_reg == HALF;
	endproperty
	property p_oe_keep;
		sclk_oe |=> sclk_oe;
	endproperty
	property p_oe_pair;
		sclk_oe == sdat_oe;
	endproperty
	property p_clk_pin;
		serial_clock_pin == (sclk_oe ? sclk_out : 1'b1);
	endproperty
	property p_dat_pin;
		serial_data_pin == (sdat_oe ? sdat_out : 1'b1);
	endproperty
	property p_stable_high;
		sclk_out && $past(sclk_out) |-> $stable(sdat_out);
	endproperty
	a_hold_high: assert property (p_hold_high)
		else $error("data moved just after link clock rose");
	a_change_low: assert property (p_change_low)
		else $error("data changed while link clock high");
	a_high_len: assert property (p_high_len)
		else $error("link clock high half has wrong length");
	a_oe_keep: assert property (p_oe_keep)
		else $error("clock drive enable dropped");
	a_oe_pair: assert property (p_oe_pair)
		else $error("clock and data enables differ");
	a_clk_pin: assert property (p_clk_pin)
		else $error("clock pin level wrong");
	a_dat_pin: assert property (p_dat_pin)
		else $error("data pin level wrong");
	a_stable_high: assert property (p_stable_high)
		else $error("data unstable in high half");
endmodule // sxr_link_checker

// ==== dv/sxr_slave_rx_test.sv ====
// self-checking bench: master end feeds the slave receiver
`timescale 1ns/100ps
module sxr_slave_rx_test
	import sxr_pkg::*;
;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	logic              send = 1'b0;
	logic              nine_bit = 1'b0;
	logic [CHAR_W-1:0] char_in = 9'h000;
	logic              busy;
	logic              done;
	logic [31:0]       q;
	logic              e;
	logic [8:0]        c [0:2];
	logic [31:0]       w;
	int                errors = 0;
	int                compares = 0;
	int                seed = 53391;
	always #5 pclk = ~pclk;
	sxr_link_if lnk();
	sxr_slave_rx i_sxr_slave_rx(.pclk, .presetn, .ce(1'b1), .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .link(lnk));
	sxr_sync_master i_sxr_sync_master(.pclk, .presetn, .ce(1'b1),
		.send, .nine_bit, .char_in, .busy, .done, .link(lnk));
	sxr_link_checker #(.HALF(LINK_HALF_CYC)) i_sxr_link_checker(
		.pclk, .presetn, .sclk_out(lnk.sclk_out),
		.sclk_oe(lnk.sclk_oe), .sdat_out(lnk.sdat_out),
		.sdat_oe(lnk.sdat_oe), .serial_clock_pin(lnk.serial_clock_pin),
		.serial_data_pin(lnk.serial_data_pin));
	// ==========================================================
	function automatic logic [31:0] stat(logic [7:0] cfg, logic o,
		logic n);
		return {24'h0, cfg[7:4], 2'b00, o, n};
	endfunction
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			errors++;
			$display("FAIL %s exp %h got %h", nm, x, s);
		end
	endtask
	task apb(input logic wt, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wt;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// access phase: everything holds until pready is seen at an edge
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, q, x);
	endtask
	task chk_irq(input logic x);
		@(negedge pclk);
		chk("irq", {31'h0, irq}, {31'h0, x});
	endtask
	// sends one character and lets the push land
	task tx(input logic nb, input logic [8:0] ch);
		@(posedge pclk);
		send <= 1'b1;
		nine_bit <= nb;
		char_in <= ch;
		@(posedge pclk);
		send <= 1'b0;
		@(negedge pclk);
		chk("busy", {31'h0, busy}, 32'h1);
		while (done !== 1'b1) @(negedge pclk);
		chk("idle", {31'h0, busy}, 32'h0);
		repeat (4) @(posedge pclk);
	endtask
	task close_out;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================================
	initial begin
		#200000;
		errors++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(8'(i * 4), (i == 3) ? 32'h1 << BIT_RCIDL : 32'h0, "reset");
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", {31'h0, e}, 32'h1);
		apb(1'b1, OFS_TX_STAT, 32'hffff_ffff);
		rd(OFS_TX_STAT, 32'h90, "tx_stat");
		apb(1'b1, OFS_TX_STAT, 32'h10);
		apb(1'b1, OFS_RX_STAT, 32'ha0);
		tx(1'b0, 9'h0a5);
		rd(OFS_INT_STAT, 32'h0, "no_continuous_receive_enable");
		apb(1'b1, OFS_INT_EN, 32'h1);
		for (int i = 0; i < 6; i++) begin
			c[0] = 9'($random(seed));
			if (i < 2)
				c[0] = i ? 9'h1ff : 9'h100;
			w = i[0] ? 32'hffff_ffff : 32'hb0;
			apb(1'b1, OFS_RX_STAT, w);
			tx(i[0], c[0]);
			chk_irq(1'b1);
			rd(OFS_INT_STAT, 32'h1, "done");
			rd(OFS_RX_STAT, stat(w[7:0], 1'b0, i[0] & c[0][8]), "st");
			rd(OFS_RX_DATA, {24'h0, c[0][7:0]}, "data");
			apb(1'b1, OFS_INT_CLR, 32'h1);
			chk_irq(1'b0);
		end
		apb(1'b1, OFS_RX_STAT, 32'hb0);
		apb(1'b1, OFS_INT_EN, 32'h0);
		tx(1'b0, 9'h03c);
		chk_irq(1'b0);
		rd(OFS_INT_STAT, 32'h1, "masked");
		rd(OFS_RX_DATA, 32'h3c, "masked_data");
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, OFS_RX_STAT, 32'hb0);
			for (int i = 0; i < 3; i++) begin
				c[i] = 9'($random(seed)) & 9'h0ff;
				tx(1'b0, c[i]);
			end
			rd(OFS_RX_STAT, stat(8'hb0, 1'b1, 1'b0), "overrun_error_flag");
			rd(OFS_INT_STAT, 32'h3, "ovr_int");
			w = k ? 32'h0 : 32'h80;
			apb(1'b1, OFS_RX_STAT, w);
			rd(OFS_RX_STAT, stat(w[7:0], 1'b0, 1'b0), "overrun_error_flag_clr");
			if (k == 0) begin
				rd(OFS_RX_DATA, {23'h0, c[0]}, "keep0");
				rd(OFS_RX_DATA, {23'h0, c[1]}, "keep1");
			end
		end
		close_out;
	end
endmodule // sxr_slave_rx_test
